//--- pdp_pkg.sv
/*
 * Shared constants and types for the port and data pointer unit.
 * Assumes an 8-bit register port and a 40 MHz core clock.
 */
package pdp_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_PORT0 = 8'h80; // First port latch.
    localparam logic [7:0] OFS_PORT1 = 8'h90; // Second port latch.
    localparam logic [7:0] OFS_PORT2 = 8'hA0; // Third port latch.
    localparam logic [7:0] OFS_PORT3 = 8'hB0; // Fourth port latch.
    localparam logic [7:0] OFS_PTR_LO = 8'h82; // Selected pointer, low.
    localparam logic [7:0] OFS_PTR_HI = 8'h83; // Selected pointer, high.
    localparam logic [7:0] OFS_AUX = 8'hA2; // Auxiliary pointer select.
    localparam logic [7:0] OFS_TM2MOD = 8'hC9; // Timer 2 mode control.

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int AUX_SEL_BIT = 0; // Pointer select.
    localparam int AUX_FLAG_BIT = 3; // User flag.
    localparam int TM2_DOWN_BIT = 0; // Down count enable.
    localparam int TM2_OE_BIT = 1; // Timer 2 output enable.
    localparam int P3_SER_OUT_BIT = 1; // Serial output.
    localparam int P3_WR_BIT = 6; // Write strobe.
    localparam int P3_RD_BIT = 7; // Read strobe.
    localparam logic [7:0] PORT_RESET = 8'hFF; // Latches after reset.
    localparam logic [15:0] PTR_RESET = 16'h0000; // Pointers after reset.

    // ------------------------------------------------------------------
    // Timing: data phase start count, counted down to zero over three core cycles
    // ------------------------------------------------------------------
    localparam logic [1:0] DATA_LAST = 2'h2;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        KIND_CODE = 2'b00, // Program fetch, 16-bit address.
        KIND_PTR = 2'b01, // Data move through the selected pointer.
        KIND_IDX = 2'b10  // Data move through an 8-bit index register.
    } pdp_kind_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ADDR = 2'b01,
        ST_DATA = 2'b10,
        ST_DONE = 2'b11
    } pdp_state_type;

endpackage

//--- pdp_sync.sv
/*
 * Two-stage synchroniser for the 32 port pins.
 * Assumes asynchronous pin levels; only the second stage is read.
 */
`timescale 1ns/1ps
`default_nettype none
module pdp_sync (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Pin levels in and synchronised levels out.
    input wire logic [31:0] d,
    output logic [31:0] q
);

    typedef struct packed {
        logic [31:0] meta; // First stage, read only by the second.
        logic [31:0] sync; // Second stage.
    } pdp_sync_type;

    pdp_sync_type s_q;
    pdp_sync_type s_d;

    // Next state: shift the pins through both stages.
    always_comb begin
        s_d.meta = d;
        s_d.sync = s_q.meta;
    end

    // Both stages clear under reset.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign q = s_q.sync;

endmodule
`default_nettype wire

//--- pdp_ptr_mem.sv
/*
 * Two 16-bit external data pointers with a registered read port.
 * Assumes byte writes aimed at one pointer and a select for reading.
 */
`timescale 1ns/1ps
`default_nettype none
module pdp_ptr_mem (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Byte write port.
    input wire logic wr_en,
    input wire logic wr_sel,
    input wire logic wr_hi,
    input wire logic [7:0] wr_byte,
    // Registered read of the selected pointer.
    input wire logic rd_sel,
    output logic [15:0] rd_data
);

    typedef struct packed {
        logic [15:0] zero; // Pointer zero.
        logic [15:0] one;  // Pointer one.
        logic [15:0] rd;   // Read register.
    } pdp_mem_type;

    pdp_mem_type s_q;
    pdp_mem_type s_d;

    // Write first, then read the updated words so a read right after
    // a write never sees stale data.
    always_comb begin
        s_d = s_q;
        if (wr_en && !wr_sel) begin
            if (wr_hi) begin
                s_d.zero[15:8] = wr_byte;
            end else begin
                s_d.zero[7:0] = wr_byte;
            end
        end
        if (wr_en && wr_sel) begin
            if (wr_hi) begin
                s_d.one[15:8] = wr_byte;
            end else begin
                s_d.one[7:0] = wr_byte;
            end
        end
        s_d.rd = rd_sel ? s_d.one : s_d.zero;
    end

    // Pointers clear under reset.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= {pdp_pkg::PTR_RESET, pdp_pkg::PTR_RESET,
                    pdp_pkg::PTR_RESET};
        end else begin
            s_q <= s_d;
        end
    end

    assign rd_data = s_q.rd;

endmodule
`default_nettype wire

//--- pdp_top.sv
/*
 * Port and data pointer unit: four 8-bit ports with their alternate
 * functions, the multiplexed external memory bus on the first and third
 * ports, the dual data pointer and the timer 2 mode register.
 * Assumes a core on REF_CLK driving the register port and the external
 * access request; pins are resolved by the surrounding pad logic.
 */
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Written one releases first-port pin.
// - First port multiplexes low address and data.
// - Other ports quasi-bidirectional, pulled high, readable.
// - Third port drives high address byte.
// - Index-register moves keep third port latch.
// - Second port bits carry timer 2 inputs.
// - Fourth port carries serial, interrupt, strobes.
// - Reset pin high gives full reset.
// - Two independent 16-bit data pointers.
// - Select bit chooses pointer zero or one.
// - Bit 3 is a plain user flag.
// - Bit 2 always reads zero.
// - Select, flag, zero bit clear on reset.
// - Output enable makes bit 0 clock out.
// - Cleared enable keeps bit 0 input/port.
// - Output and down-count enables clear on reset.
module pdp_top (
    // Clock and reset.
    input wire logic REF_CLK,
    input wire logic RESET,
    // Register port.
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR_STB,
    input wire logic RD_STB,
    output logic [7:0] RDATA,
    // External access request from the core.
    input wire logic EXT_REQ,
    input wire logic [1:0] EXT_KIND,
    input wire logic EXT_WRITE,
    input wire logic [15:0] EXT_ADDR,
    input wire logic [7:0] EXT_WDATA,
    output logic EXT_BUSY,
    output logic EXT_DONE,
    output logic [7:0] EXT_RDATA,
    // Alternate output sources from the core.
    input wire logic TM2_CLK_OUT,
    input wire logic SER_OUT,
    // Alternate inputs to the core.
    output logic TM2_COUNT_IN,
    output logic TM2_RELOAD_IN,
    output logic SER_IN,
    output logic EXT_IRQ0_IN,
    output logic EXT_IRQ1_IN,
    output logic TM0_IN,
    output logic TM1_IN,
    output logic DOWN_COUNT_EN,
    // Bus strobes.
    output logic ADDR_LATCH,
    output logic PROG_STROBE_N,
    // Port pins.
    input wire logic [7:0] P0_IN,
    output logic [7:0] P0_OUT,
    output logic [7:0] P0_OE_N,
    input wire logic [7:0] P1_IN,
    output logic [7:0] P1_OUT,
    output logic [7:0] P1_OE_N,
    input wire logic [7:0] P2_IN,
    output logic [7:0] P2_OUT,
    output logic [7:0] P2_OE_N,
    input wire logic [7:0] P3_IN,
    output logic [7:0] P3_OUT,
    output logic [7:0] P3_OE_N
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        pdp_pkg::pdp_state_type state; // Access sequencer.
        logic [1:0] cnt;               // Data phase countdown.
        pdp_pkg::pdp_kind_type kind;   // Kind of access in flight.
        logic wr;                      // Access is a write.
        logic [15:0] addr;             // Access address.
        logic [7:0] wdata;             // Access write data.
        logic [7:0] p0_latch;          // Port latches.
        logic [7:0] p1_latch;
        logic [7:0] p2_latch;
        logic [7:0] p3_latch;
        logic sel;                     // Pointer select.
        logic flag;                    // User flag.
        logic tmr_oe;                  // Timer 2 output enable.
        logic dn_en;                   // Down count enable.
        logic [7:0] rdata;             // Register read data.
        logic done;                    // Access done pulse.
        logic busy;                    // Access in flight.
        logic [7:0] ext_rdata;         // Access read data.
        logic [7:0] p0_out;            // Pin drive registers.
        logic [7:0] p0_oen;
        logic [7:0] p1_lvl;
        logic [7:0] p2_out;
        logic [7:0] p2_oen;
        logic [7:0] p3_lvl;
        logic ale;                     // Address latch strobe.
        logic psen_n;                  // Program read strobe.
        logic [6:0] alt_in;            // Registered alternate inputs.
    } pdp_top_type;

    // Reset image: latches high so every pin floats or pulls up.
    localparam pdp_top_type S_RESET = '{
        state: pdp_pkg::ST_IDLE, cnt: 2'h0, kind: pdp_pkg::KIND_CODE,
        wr: 1'b0, addr: 16'h0000, wdata: 8'h00,
        p0_latch: pdp_pkg::PORT_RESET, p1_latch: pdp_pkg::PORT_RESET,
        p2_latch: pdp_pkg::PORT_RESET, p3_latch: pdp_pkg::PORT_RESET,
        sel: 1'b0, flag: 1'b0, tmr_oe: 1'b0, dn_en: 1'b0,
        rdata: 8'h00, done: 1'b0, busy: 1'b0, ext_rdata: 8'h00,
        p0_out: 8'h00, p0_oen: pdp_pkg::PORT_RESET,
        p1_lvl: pdp_pkg::PORT_RESET, p2_out: 8'h00,
        p2_oen: pdp_pkg::PORT_RESET, p3_lvl: pdp_pkg::PORT_RESET,
        ale: 1'b0, psen_n: 1'b1, alt_in: 7'h00
    };

    pdp_top_type s_q;
    pdp_top_type n;
    logic [31:0] pin_s;    // Synchronised pins.
    logic [15:0] ptr_word; // Currently selected pointer.
    logic ptr_wr;          // Register write to a pointer byte.

    // ------------------------------------------------------------------
    // Leaf instances
    // ------------------------------------------------------------------
    // Pins are asynchronous to REF_CLK, so nothing reads them raw.
    pdp_sync u_sync (
        .clk(REF_CLK),
        .rst(RESET),
        .d({P3_IN, P2_IN, P1_IN, P0_IN}),
        .q(pin_s)
    );

    assign ptr_wr = WR_STB && (ADDR == pdp_pkg::OFS_PTR_LO ||
                               ADDR == pdp_pkg::OFS_PTR_HI);

    // The read select uses the next select value so a read or an
    // access right after a select change sees the new pointer.
    pdp_ptr_mem u_ptr (
        .clk(REF_CLK),
        .rst(RESET),
        .wr_en(ptr_wr),
        .wr_sel(s_q.sel),
        .wr_hi(ADDR == pdp_pkg::OFS_PTR_HI),
        .wr_byte(WDATA),
        .rd_sel(n.sel),
        .rd_data(ptr_word)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        n = s_q;
        n.done = 1'b0;
        n.rdata = 8'h00;
        // Register writes; reserved bits are simply not stored.
        if (WR_STB) begin
            case (ADDR)
                pdp_pkg::OFS_PORT0: n.p0_latch = WDATA;
                pdp_pkg::OFS_PORT1: n.p1_latch = WDATA;
                pdp_pkg::OFS_PORT2: n.p2_latch = WDATA;
                pdp_pkg::OFS_PORT3: n.p3_latch = WDATA;
                pdp_pkg::OFS_AUX: begin
                    n.sel = WDATA[pdp_pkg::AUX_SEL_BIT];
                    n.flag = WDATA[pdp_pkg::AUX_FLAG_BIT];
                end
                pdp_pkg::OFS_TM2MOD: begin
                    n.tmr_oe = WDATA[pdp_pkg::TM2_OE_BIT];
                    n.dn_en = WDATA[pdp_pkg::TM2_DOWN_BIT];
                end
                default: begin
                end
            endcase
        end
        // Register reads; ports return pin levels, unmapped reads zero.
        if (RD_STB) begin
            case (ADDR)
                pdp_pkg::OFS_PORT0: n.rdata = pin_s[7:0];
                pdp_pkg::OFS_PORT1: n.rdata = pin_s[15:8];
                pdp_pkg::OFS_PORT2: n.rdata = pin_s[23:16];
                pdp_pkg::OFS_PORT3: n.rdata = pin_s[31:24];
                pdp_pkg::OFS_PTR_LO: n.rdata = ptr_word[7:0];
                pdp_pkg::OFS_PTR_HI: n.rdata = ptr_word[15:8];
                pdp_pkg::OFS_AUX: begin
                    // Bit 2 and the reserved bits read zero.
                    n.rdata = {4'h0, s_q.flag, 2'b00, s_q.sel};
                end
                pdp_pkg::OFS_TM2MOD: n.rdata = {6'h00, s_q.tmr_oe, s_q.dn_en};
                default: n.rdata = 8'h00;
            endcase
        end
        // Access sequencer: address phase, data phase, done.
        unique case (s_q.state)
            pdp_pkg::ST_IDLE: begin
                if (EXT_REQ) begin
                    n.state = pdp_pkg::ST_ADDR;
                    n.kind = pdp_pkg::pdp_kind_type'(EXT_KIND);
                    n.wr = EXT_WRITE;
                    n.wdata = EXT_WDATA;
                    // Pointer moves take the selected pointer.
                    if (EXT_KIND == pdp_pkg::KIND_PTR) begin
                        n.addr = ptr_word;
                    end else begin
                        n.addr = EXT_ADDR;
                    end
                end
            end
            pdp_pkg::ST_ADDR: begin
                n.state = pdp_pkg::ST_DATA;
                n.cnt = pdp_pkg::DATA_LAST;
            end
            pdp_pkg::ST_DATA: begin
                if (s_q.cnt == 2'h0) begin
                    n.state = pdp_pkg::ST_DONE;
                    n.done = 1'b1;
                    n.ext_rdata = pin_s[7:0];
                end else begin
                    n.cnt = s_q.cnt - 2'h1;
                end
            end
            pdp_pkg::ST_DONE: n.state = pdp_pkg::ST_IDLE;
        endcase
        // First port: address, then data, else open drain from latch.
        if (n.state == pdp_pkg::ST_ADDR) begin
            n.p0_out = n.addr[7:0];
            n.p0_oen = 8'h00;
        end else if (n.state == pdp_pkg::ST_DATA && n.wr &&
                     n.kind != pdp_pkg::KIND_CODE) begin
            n.p0_out = n.wdata;
            n.p0_oen = 8'h00;
        end else if (n.state == pdp_pkg::ST_DATA) begin
            n.p0_out = 8'h00;
            n.p0_oen = 8'hFF;
        end else begin
            n.p0_out = 8'h00;
            n.p0_oen = n.p0_latch;
        end
        // Third port: strong high address, except index moves.
        if ((n.state == pdp_pkg::ST_ADDR || n.state == pdp_pkg::ST_DATA)
            && n.kind != pdp_pkg::KIND_IDX) begin
            n.p2_out = n.addr[15:8];
            n.p2_oen = 8'h00;
        end else begin
            n.p2_out = 8'h00;
            n.p2_oen = n.p2_latch;
        end
        // Second port: bit 0 follows the timer clock when enabled.
        n.p1_lvl = n.p1_latch;
        if (n.tmr_oe) begin
            n.p1_lvl[0] = n.p1_latch[0] & TM2_CLK_OUT;
        end
        // Fourth port: latch gated with serial output and strobes.
        n.p3_lvl = n.p3_latch;
        n.p3_lvl[pdp_pkg::P3_SER_OUT_BIT] =
            n.p3_latch[pdp_pkg::P3_SER_OUT_BIT] & SER_OUT;
        if (n.state == pdp_pkg::ST_DATA &&
            n.kind != pdp_pkg::KIND_CODE) begin
            n.p3_lvl[pdp_pkg::P3_WR_BIT] =
                n.p3_latch[pdp_pkg::P3_WR_BIT] & ~n.wr;
            n.p3_lvl[pdp_pkg::P3_RD_BIT] =
                n.p3_latch[pdp_pkg::P3_RD_BIT] & n.wr;
        end
        n.ale = (n.state == pdp_pkg::ST_ADDR);
        n.busy = (n.state != pdp_pkg::ST_IDLE);
        n.psen_n = ~(n.state == pdp_pkg::ST_DATA &&
                     n.kind == pdp_pkg::KIND_CODE);
        // Alternate inputs; the count input is masked as clock output.
        n.alt_in[0] = n.tmr_oe ? 1'b0 : pin_s[8];
        n.alt_in[1] = pin_s[9];
        n.alt_in[2] = pin_s[24];
        n.alt_in[3] = pin_s[26];
        n.alt_in[4] = pin_s[27];
        n.alt_in[5] = pin_s[28];
        n.alt_in[6] = pin_s[29];
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    // The reset pin loads the reset image into everything at once, clock or not.
    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            s_q <= S_RESET;
        end else begin
            s_q <= n;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, all from flip-flops
    // ------------------------------------------------------------------
    assign RDATA = s_q.rdata;
    assign EXT_BUSY = s_q.busy;
    assign EXT_DONE = s_q.done;
    assign EXT_RDATA = s_q.ext_rdata;
    assign TM2_COUNT_IN = s_q.alt_in[0];
    assign TM2_RELOAD_IN = s_q.alt_in[1];
    assign SER_IN = s_q.alt_in[2];
    assign EXT_IRQ0_IN = s_q.alt_in[3];
    assign EXT_IRQ1_IN = s_q.alt_in[4];
    assign TM0_IN = s_q.alt_in[5];
    assign TM1_IN = s_q.alt_in[6];
    assign DOWN_COUNT_EN = s_q.dn_en;
    assign ADDR_LATCH = s_q.ale;
    assign PROG_STROBE_N = s_q.psen_n;
    assign P0_OUT = s_q.p0_out;
    assign P0_OE_N = s_q.p0_oen;
    // Quasi pins drive low for a zero and release for a one.
    assign P1_OUT = s_q.p1_lvl;
    assign P1_OE_N = s_q.p1_lvl;
    assign P2_OUT = s_q.p2_out;
    assign P2_OE_N = s_q.p2_oen;
    assign P3_OUT = s_q.p3_lvl;
    assign P3_OE_N = s_q.p3_lvl;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_p0_release_idle: assert property (@(posedge REF_CLK) disable iff
        (RESET) s_q.state == pdp_pkg::ST_IDLE |->
        P0_OE_N == s_q.p0_latch) else $error("p0 not from latch");
    a_p0_addr_phase: assert property (@(posedge REF_CLK) disable iff
        (RESET) s_q.state == pdp_pkg::ST_ADDR |-> P0_OE_N == 8'h00 &&
        P0_OUT == s_q.addr[7:0] && ADDR_LATCH)
        else $error("p0 address phase wrong");
    a_access_length: assert property (@(posedge REF_CLK) disable iff
        (RESET) s_q.state == pdp_pkg::ST_ADDR |-> !EXT_DONE [*4]
        ##1 EXT_DONE) else $error("access length wrong");
    a_p3_quasi_pins: assert property (@(posedge REF_CLK) disable iff
        (RESET) P3_OE_N[5:2] == s_q.p3_latch[5:2])
        else $error("p3 pins not latch");
    a_p2_high_addr: assert property (@(posedge REF_CLK) disable iff
        (RESET) s_q.state == pdp_pkg::ST_ADDR &&
        s_q.kind != pdp_pkg::KIND_IDX |-> P2_OE_N == 8'h00 &&
        P2_OUT == s_q.addr[15:8]) else $error("p2 address wrong");
    a_p2_keeps_latch: assert property (@(posedge REF_CLK) disable iff
        (RESET) s_q.kind == pdp_pkg::KIND_IDX |->
        P2_OE_N == s_q.p2_latch) else $error("p2 not latch");
    a_ptr_address: assert property (@(posedge REF_CLK) disable iff
        (RESET) s_q.state == pdp_pkg::ST_IDLE && EXT_REQ &&
        EXT_KIND == pdp_pkg::KIND_PTR |=> s_q.addr == $past(ptr_word))
        else $error("pointer address wrong");
    a_aux_readback: assert property (@(posedge REF_CLK) disable iff
        (RESET) RD_STB && ADDR == pdp_pkg::OFS_AUX |=> RDATA ==
        {4'h0, $past(s_q.flag), 2'b00, $past(s_q.sel)})
        else $error("aux read wrong");
    a_tm2_clk_out: assert property (@(posedge REF_CLK) disable iff
        (RESET) s_q.tmr_oe && s_q.p1_latch[0] && !WR_STB |=>
        P1_OE_N[0] == $past(TM2_CLK_OUT))
        else $error("clock output wrong");
    a_tm2_in_mask: assert property (@(posedge REF_CLK) disable iff
        (RESET) s_q.tmr_oe && $past(s_q.tmr_oe) |-> !TM2_COUNT_IN)
        else $error("count input not masked");

endmodule
`default_nettype wire

//--- pdp_mem_model.sv
/* External program and data memory on the multiplexed bus.
   Assumes the bench resolves the third and fourth port pins. */
`timescale 1ns/1ps
`default_nettype none
module pdp_mem_model (
    // Clock.
    input wire logic clk,
    // Board-side pins.
    input wire logic [7:0] p0_out,
    input wire logic [7:0] p0_oe_n,
    input wire logic [7:0] p2_pin,
    input wire logic [7:0] p3_pin,
    input wire logic ale,
    input wire logic psen_n,
    // Resolved first port and captured bus values.
    output logic [7:0] p0_pin,
    output logic [15:0] addr_q,
    output logic [7:0] wdat_q
);
    // ----------------------------------------------------------
    // Memory behaviour
    // ----------------------------------------------------------
    logic [7:0] last_q = 8'hA5; // Floating bus shows the inverse.
    logic rd_on; // Memory drives the bus while a read strobe is low.
    logic [7:0] drv; // Memory data or a floating level.
    assign rd_on = !psen_n || !p3_pin[7];
    // Data is a fixed function of the address so any mix-up shows.
    assign drv = rd_on ? (addr_q[7:0] ^ ~addr_q[15:8]) : ~last_q;
    assign p0_pin = (~p0_oe_n & p0_out) | (p0_oe_n & drv);
    // Latch the address while the strobe is high, data on write.
    always @(posedge clk) begin
        last_q <= p0_pin;
        if (ale) addr_q <= {p2_pin, p0_pin};
        if (!p3_pin[6]) wdat_q <= p0_pin;
    end
endmodule
`default_nettype wire

//--- test_port_and_data_pointer_unit.sv
/* Self-checking bench for the port and data pointer unit.
   Assumes the memory model and pull-ups on the second to fourth ports. */
`timescale 1ns/1ps
`default_nettype none
module test_port_and_data_pointer_unit;
    // ----------------------------------------------------------
    // Stimulus, pins and bookkeeping
    // ----------------------------------------------------------
    logic ref_clk = 0, reset = 1, wr_stb = 0, rd_stb = 0, ext_req = 0;
    logic [7:0] addr = 0, wdata = 0, ext_wdata = 0, v;
    logic [1:0] ext_kind = 0;
    logic ext_write = 0, tmr_clk = 0, ser_out = 1;
    logic [15:0] ext_addr = 0;
    logic [7:0] p1_ext = 8'hFF, p3_ext = 8'hFF; // Board pull-downs.
    logic [7:0] rdata, ext_rdata, p0_in, p0_out, p0_oe_n, p1_out, p1_oe_n;
    logic [7:0] p2_out, p2_oe_n, p3_out, p3_oe_n, p1_in, p2_in, p3_in;
    logic ext_done, tmr_cnt, ser_in, tmr0_in, dn_en, ale, psen_n;
    logic ext_busy, tmr_rel, irq0, irq1, tmr1_in;
    logic [15:0] maddr;
    logic [7:0] mwdat;
    int err_total = 0, comparisons = 0, cyc = 0;
    // Released pins are pulled high unless the board pulls them low.
    assign p1_in = (p1_out | p1_oe_n) & p1_ext;
    assign p2_in = p2_out | p2_oe_n;
    assign p3_in = (p3_out | p3_oe_n) & p3_ext;
    always #12.5 ref_clk = ~ref_clk;
    pdp_top u_dut (.REF_CLK(ref_clk), .RESET(reset), .ADDR(addr),
        .WDATA(wdata), .WR_STB(wr_stb), .RD_STB(rd_stb), .RDATA(rdata),
        .EXT_REQ(ext_req), .EXT_KIND(ext_kind), .EXT_WRITE(ext_write),
        .EXT_ADDR(ext_addr), .EXT_WDATA(ext_wdata), .EXT_BUSY(ext_busy),
        .EXT_DONE(ext_done), .EXT_RDATA(ext_rdata),
        .TM2_CLK_OUT(tmr_clk), .SER_OUT(ser_out), .TM2_COUNT_IN(tmr_cnt),
        .TM2_RELOAD_IN(tmr_rel), .SER_IN(ser_in), .EXT_IRQ0_IN(irq0),
        .EXT_IRQ1_IN(irq1), .TM0_IN(tmr0_in), .TM1_IN(tmr1_in),
        .DOWN_COUNT_EN(dn_en), .ADDR_LATCH(ale),
        .PROG_STROBE_N(psen_n), .P0_IN(p0_in), .P0_OUT(p0_out),
        .P0_OE_N(p0_oe_n), .P1_IN(p1_in), .P1_OUT(p1_out),
        .P1_OE_N(p1_oe_n), .P2_IN(p2_in), .P2_OUT(p2_out),
        .P2_OE_N(p2_oe_n), .P3_IN(p3_in), .P3_OUT(p3_out),
        .P3_OE_N(p3_oe_n));
    pdp_mem_model u_mem (.clk(ref_clk), .p0_out(p0_out), .p0_oe_n(p0_oe_n),
        .p2_pin(p2_in), .p3_pin(p3_in), .ale(ale), .psen_n(psen_n),
        .p0_pin(p0_in), .addr_q(maddr), .wdat_q(mwdat));
    // ----------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------
    task chk(input logic [15:0] s, input logic [15:0] e);
        comparisons++;
        if (s !== e) begin
            err_total++;
            $display("BAD %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task results;
        $display("checks %0d errors %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr <= a; wdata <= d; wr_stb <= 1;
        @(posedge ref_clk);
        wr_stb <= 0;
    endtask
    // Read data stands only in the cycle after the strobe.
    task rd(input logic [7:0] a);
        @(posedge ref_clk);
        addr <= a; rd_stb <= 1;
        @(posedge ref_clk);
        rd_stb <= 0;
        #1 v = rdata;
    endtask
    // One external access; the wait for completion is bounded.
    task acc(input logic [1:0] k, input logic w, input logic [15:0] a,
             input logic [7:0] d);
        int n;
        @(posedge ref_clk);
        ext_req <= 1; ext_kind <= k; ext_write <= w;
        ext_addr <= a; ext_wdata <= d;
        @(posedge ref_clk);
        ext_req <= 0;
        for (n = 0; n < 20 && ext_done !== 1'b1; n++) @(posedge ref_clk) #1;
        chk(ext_done, 1'b1);
        chk(ext_busy, 1'b1);
    endtask
    function automatic logic [7:0] mdat(input logic [15:0] a);
        return a[7:0] ^ ~a[15:8];
    endfunction
    // ----------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------
    task t_reset;
        chk(p0_oe_n, 8'hFF);
        chk(ext_busy, 1'b0);
        rd(8'hA2); chk(v, 8'h00);
        rd(pdp_pkg::OFS_TM2MOD); chk(v, 8'h00);
        rd(8'h55); chk(v, 8'h00);
    endtask
    task t_aux;
        wr(pdp_pkg::OFS_AUX, 8'h0D);
        rd(pdp_pkg::OFS_AUX); chk(v, 8'h09);
    endtask
    task t_ptr;
        wr(pdp_pkg::OFS_AUX, 8'h00);
        wr(8'h82, 8'h34); wr(8'h83, 8'h12);
        wr(pdp_pkg::OFS_AUX, 8'h01);
        wr(8'h82, 8'hCD); wr(8'h83, 8'hAB);
        rd(8'h83); chk(v, 8'hAB);
        wr(pdp_pkg::OFS_AUX, 8'h00);
        rd(8'h82); chk(v, 8'h34);
        wr(pdp_pkg::OFS_AUX, 8'h01);
    endtask
    task t_move;
        acc(2'h1, 1'b0, 16'h0000, 8'h00);
        chk(maddr, 16'hABCD);
        chk(ext_rdata, mdat(16'hABCD));
        acc(2'h1, 1'b1, 16'h0000, 8'h3C);
        chk(mwdat, 8'h3C);
        chk(p0_oe_n, 8'hFF);
        wr(pdp_pkg::OFS_PORT2, 8'h5C);
        acc(2'h2, 1'b0, 16'hFF77, 8'h00);
        chk(maddr, 16'h5C77);
        acc(2'h0, 1'b0, 16'h2468, 8'h00);
        chk(maddr, 16'h2468);
        chk(ext_rdata, mdat(16'h2468));
    endtask
    task t_timer;
        wr(pdp_pkg::OFS_TM2MOD, 8'h03);
        tmr_clk <= 1;
        repeat (2) @(posedge ref_clk);
        #1 chk(p1_out[0], 1'b1);
        chk(dn_en, 1'b1);
        chk(tmr_cnt, 1'b0);
        @(posedge ref_clk);
        tmr_clk <= 0;
        repeat (2) @(posedge ref_clk);
        #1 chk(p1_out[0], 1'b0);
        wr(pdp_pkg::OFS_TM2MOD, 8'h00);
        p1_ext <= 8'hFE;
        repeat (5) @(posedge ref_clk);
        #1 chk(tmr_cnt, 1'b0);
        chk(tmr_rel, 1'b1);
        p1_ext <= 8'hFF;
        repeat (5) @(posedge ref_clk);
        #1 chk(tmr_cnt, 1'b1);
    endtask
    task t_port3;
        p3_ext <= 8'hEE;
        ser_out <= 0;
        repeat (5) @(posedge ref_clk);
        #1 chk(ser_in, 1'b0);
        chk(tmr0_in, 1'b0);
        chk(irq0, 1'b1);
        chk(irq1, 1'b1);
        chk(tmr1_in, 1'b1);
        chk(p3_out[1], 1'b0);
        p3_ext <= 8'hFF;
        ser_out <= 1;
    endtask
    // ----------------------------------------------------------
    // Sequence and hang guard
    // ----------------------------------------------------------
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            results;
        end
    end
    initial begin
        repeat (16) @(posedge ref_clk);
        reset <= 0;
        #1 t_reset;
        t_aux;
        t_ptr;
        t_move;
        t_timer;
        t_port3;
        results;
    end
endmodule
`default_nettype wire
